// ==== rmss_defines.vh ====
// register offsets, field positions, reset values for the misc status bank
`ifndef RMSS_DEFINES_VH
`define RMSS_DEFINES_VH

// bus widths
`define RMSS_ADDR_W 8
`define RMSS_DATA_W 8

// register offsets
`define RMSS_OFF_MISC_STS 8'h1C
`define RMSS_OFF_FORCE_CHG 8'h1E
`define RMSS_OFF_RATE_SHD 8'h1F
`define RMSS_OFF_FIFO_SHD 8'h20
`define RMSS_OFF_EDGE_SEL 8'h21
`define RMSS_OFF_KBD_STS 8'h24
`define RMSS_OFF_MISC_MASK 8'h25
`define RMSS_OFF_KBD_MASK 8'h26

// reset values
`define RMSS_RST_MISC_STS 6'h00
`define RMSS_RST_FORCE_CHG 2'h3
`define RMSS_RST_RATE_SHD 8'h02
`define RMSS_RST_FIFO_SHD 8'h00
`define RMSS_RST_EDGE_SEL 4'h0
`define RMSS_RST_KBD_STS 4'h0
`define RMSS_RST_MASK 6'h00
`define RMSS_RST_KBD_MASK 4'h0

// live bit masks of the status, force, shadow and edge select registers
`define RMSS_MISC_STS_BITS 8'h3F
`define RMSS_FORCE_CHG_BITS 8'h03
`define RMSS_RATE_SHD_BITS 8'hDF
`define RMSS_FIFO_SHD_BITS 8'hCF
`define RMSS_EDGE_SEL_BITS 8'h0F
`define RMSS_KBD_STS_BITS 8'h0F

// field positions, forced disk change
`define RMSS_FCHG_DRV0 0
`define RMSS_FCHG_DRV1 1

// field positions, edge select and keyboard event status
`define RMSS_KBD_P2_SMI 0
`define RMSS_KBD_P6_SMI 1
`define RMSS_KBD_P2_WAKE 2
`define RMSS_KBD_P6_WAKE 3

// answer to an unmapped read
`define RMSS_UNMAPPED_DATA 8'h00

`endif

// ==== rmss_regs.v ====
// runtime misc status, forced disk change, shadows and edge select registers
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "rmss_defines.vh"

// overview
// six sticky either-edge flags, cleared by writing one
// two forced disk change bits, one per drive
// software only sets them, a step to the drive clears them
// disk change indication ORs the force of each selected drive with the pin
// two read-only shadows follow writes in other blocks
// floppy data-rate shadow, serial fifo control shadow
// four keyboard flags, smi and wake for pins 2 and 6
// falling edges always count, rising ones by select bit
// one level interrupt from all unmasked flags
// own offsets 0x24 to 0x26 hold keyboard status and masks
// limitations
// one synchronous reset stands in for all power resets
// pins are taken as synchronous, no synchroniser here
// a pulse shorter than a clock cycle may be missed
// edges in the first cycle after reset are ignored
// trade-off: outputs are flops, so indication lags a cycle

module rmss_regs #(
  parameter NUM_EDGE = 6 // number of either-edge inputs
) (
  // clock and reset
  input wire clk_in,
  input wire srst_in,
  // register port
  // read data one cycle after the read strobe
  input wire [`RMSS_ADDR_W-1:0] addr_in,
  input wire [`RMSS_DATA_W-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [`RMSS_DATA_W-1:0] rdata_out,
  // either-edge pins
  input wire edge_input_a_in,
  input wire edge_input_b_in,
  input wire edge_input_c_in,
  input wire edge_input_d_in,
  input wire edge_input_e_in,
  input wire edge_input_f_in,
  // floppy drive pins
  input wire step_pulse_n_in,
  input wire drive0_select_n_in,
  input wire drive1_select_n_in,
  input wire disk_change_in_n_in,
  output wire disk_change_indication_out,
  // source register writes in the floppy and serial blocks
  input wire rate_src_wr_in,
  input wire [`RMSS_DATA_W-1:0] rate_src_data_in,
  input wire fifo_src_wr_in,
  input wire [`RMSS_DATA_W-1:0] fifo_src_data_in,
  // keyboard port pins
  input wire kbd_port_pin2_in,
  input wire kbd_port_pin6_in,
  // keyboard event flags, smi and wake
  output wire [3:0] kbd_event_out,
  // interrupt
  output wire irq_out
);

  // decide whether a keyboard pin edge counts
  // a falling edge always counts, a rising one only when both is chosen
  // shared by all four keyboard flags, two per pin
  function edge_hit;
    input prev_lvl;
    input cur_lvl;
    input both_sel;
    begin
      edge_hit = (prev_lvl & ~cur_lvl) | (both_sel & ~prev_lvl & cur_lvl);
    end
  endfunction

  // address decode
  wire hit_misc = (addr_in == `RMSS_OFF_MISC_STS);
  wire hit_force = (addr_in == `RMSS_OFF_FORCE_CHG);
  // shadow offsets need no write decode, bus writes never reach them
  wire hit_edge = (addr_in == `RMSS_OFF_EDGE_SEL);
  wire hit_kbd = (addr_in == `RMSS_OFF_KBD_STS);
  wire hit_mmask = (addr_in == `RMSS_OFF_MISC_MASK);
  wire hit_kmask = (addr_in == `RMSS_OFF_KBD_MASK);

  // qualified write strobes
  // reads have no side effects, so only writes are qualified
  wire wr_misc = wr_in & hit_misc;
  wire wr_force = wr_in & hit_force;
  wire wr_edge = wr_in & hit_edge;
  wire wr_kbd = wr_in & hit_kbd;
  wire wr_mmask = wr_in & hit_mmask;
  wire wr_kmask = wr_in & hit_kmask;

  // state registers
  // every stored bit below has a reset value
  reg [NUM_EDGE-1:0] misc_sts_reg; // sticky either-edge flags
  reg [NUM_EDGE-1:0] misc_sts_next;
  reg [NUM_EDGE-1:0] edge_prev_reg; // last sampled level of each pin
  reg [1:0] force_reg; // forced disk change per drive
  reg [1:0] force_next;
  reg [7:0] rate_shd_reg; // floppy data-rate shadow
  reg [7:0] fifo_shd_reg; // serial fifo control shadow
  reg [3:0] edge_sel_reg; // keyboard edge selects
  reg [3:0] kbd_sts_reg; // keyboard smi and wake flags
  reg [3:0] kbd_sts_next;
  reg [NUM_EDGE-1:0] misc_mask_reg; // interrupt mask for edge flags
  reg [NUM_EDGE-1:0] misc_mask_next;
  reg [3:0] kbd_mask_reg; // interrupt mask for keyboard flags
  reg [3:0] kbd_mask_next;
  reg kbd_p2_prev_reg; // last level of keyboard pin 2
  reg kbd_p6_prev_reg; // last level of keyboard pin 6
  reg prev_valid_reg; // previous levels hold real samples
  reg [7:0] rdata_reg; // read answer
  reg chg_ind_reg; // disk change indication
  reg irq_reg; // interrupt level

  // gather the edge pins into a vector, bit 0 is input a
  wire [NUM_EDGE-1:0] edge_pins = {edge_input_f_in, edge_input_e_in, edge_input_d_in,
    edge_input_c_in, edge_input_b_in, edge_input_a_in};

  // either-edge detect per pin
  // suppressed on the first cycle after reset, else a stale zero looks like an edge
  // a pin that toggles every cycle sets its flag each time
  wire [NUM_EDGE-1:0] edge_evt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EDGE; gi = gi + 1) begin : g_edge
      assign edge_evt[gi] = prev_valid_reg & (edge_prev_reg[gi] ^ edge_pins[gi]);
    end
  endgenerate

  // keyboard pin events, one per flag
  // pin 2 feeds bits 0 and 2, pin 6 feeds bits 1 and 3
  wire [3:0] kbd_evt;
  assign kbd_evt[`RMSS_KBD_P2_SMI] = prev_valid_reg &
    edge_hit(kbd_p2_prev_reg, kbd_port_pin2_in, edge_sel_reg[`RMSS_KBD_P2_SMI]);
  assign kbd_evt[`RMSS_KBD_P6_SMI] = prev_valid_reg &
    edge_hit(kbd_p6_prev_reg, kbd_port_pin6_in, edge_sel_reg[`RMSS_KBD_P6_SMI]);
  assign kbd_evt[`RMSS_KBD_P2_WAKE] = prev_valid_reg &
    edge_hit(kbd_p2_prev_reg, kbd_port_pin2_in, edge_sel_reg[`RMSS_KBD_P2_WAKE]);
  assign kbd_evt[`RMSS_KBD_P6_WAKE] = prev_valid_reg &
    edge_hit(kbd_p6_prev_reg, kbd_port_pin6_in, edge_sel_reg[`RMSS_KBD_P6_WAKE]);

  // drive selected and stepping, all pins active low
  // both selects low at once is not refused, both bits may clear
  wire drv0_sel = ~drive0_select_n_in;
  wire drv1_sel = ~drive1_select_n_in;
  wire stepping = ~step_pulse_n_in;

  // next value of the sticky edge flags
  // bits above the six flags are not stored at all
  always @* begin
    misc_sts_next = misc_sts_reg;
    // write one clears, write zero leaves alone
    if (wr_misc) begin
      misc_sts_next = misc_sts_next & ~wdata_in[NUM_EDGE-1:0];
    end
    // set after clear so a same-cycle edge survives
    misc_sts_next = misc_sts_next | edge_evt;
  end

  // next value of the keyboard flags, same clear-then-set order
  // cleared by writing one at their own offset
  always @* begin
    kbd_sts_next = kbd_sts_reg;
    if (wr_kbd) begin
      kbd_sts_next = kbd_sts_next & ~wdata_in[3:0];
    end
    kbd_sts_next = kbd_sts_next | kbd_evt;
  end

  // next value of the forced disk change bits
  // written as clear first, then set, so a set write wins
  always @* begin
    force_next = force_reg;
    // hardware clears on step to the selected drive
    // a step with no drive selected clears nothing
    if (stepping & drv0_sel) begin
      force_next[`RMSS_FCHG_DRV0] = 1'b0;
    end
    if (stepping & drv1_sel) begin
      force_next[`RMSS_FCHG_DRV1] = 1'b0;
    end
    // software may only set; a software set beats a same-cycle step clear
    if (wr_force) begin
      force_next = force_next | wdata_in[1:0];
    end
  end

  // sticky flags and previous levels
  always @(posedge clk_in) begin
    if (srst_in) begin
      // flags clear, previous levels not yet valid
      misc_sts_reg <= `RMSS_RST_MISC_STS;
      kbd_sts_reg <= `RMSS_RST_KBD_STS;
      edge_prev_reg <= {NUM_EDGE{1'b0}};
      kbd_p2_prev_reg <= 1'b0;
      kbd_p6_prev_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
    end else begin
      // flags follow their next values
      misc_sts_reg <= misc_sts_next;
      kbd_sts_reg <= kbd_sts_next;
      // pins are taken as synchronous, no extra stage
      edge_prev_reg <= edge_pins;
      kbd_p2_prev_reg <= kbd_port_pin2_in;
      kbd_p6_prev_reg <= kbd_port_pin6_in;
      prev_valid_reg <= 1'b1;
    end
  end

  // forced disk change bits
  always @(posedge clk_in) begin
    if (srst_in) begin
      // both drives start flagged as changed
      force_reg <= `RMSS_RST_FORCE_CHG;
    end else begin
      // step clears and software sets
      force_reg <= force_next;
    end
  end

  // shadows copy the source writes, bus writes never reach them
  // the source blocks own the real registers, these are only copies
  // reserved shadow bits are dropped rather than copied
  always @(posedge clk_in) begin
    if (srst_in) begin
      // shadow reset values
      rate_shd_reg <= `RMSS_RST_RATE_SHD;
      fifo_shd_reg <= `RMSS_RST_FIFO_SHD;
    end else begin
      // floppy data-rate source written
      if (rate_src_wr_in) begin
        rate_shd_reg <= rate_src_data_in & `RMSS_RATE_SHD_BITS;
      end
      // serial fifo control source written
      if (fifo_src_wr_in) begin
        fifo_shd_reg <= fifo_src_data_in & `RMSS_FIFO_SHD_BITS;
      end
    end
  end

  // plain read/write control registers
  always @(posedge clk_in) begin
    if (srst_in) begin
      // selects and masks start cleared
      edge_sel_reg <= `RMSS_RST_EDGE_SEL;
      misc_mask_reg <= `RMSS_RST_MASK;
      kbd_mask_reg <= `RMSS_RST_KBD_MASK;
    end else begin
      // edge selects steer the keyboard event logic
      if (wr_edge) begin
        edge_sel_reg <= wdata_in[3:0];
      end
      // interrupt masks, decided in their next-value process
      misc_mask_reg <= misc_mask_next;
      kbd_mask_reg <= kbd_mask_next;
    end
  end

  // next value of the interrupt masks
  // irq reads these, so a mask write acts in the same cycle
  // without them irq would stay up one cycle after masking
  always @* begin
    misc_mask_next = misc_mask_reg;
    kbd_mask_next = kbd_mask_reg;
    // misc status mask
    if (wr_mmask) begin
      misc_mask_next = wdata_in[NUM_EDGE-1:0];
    end
    // keyboard flag mask
    if (wr_kmask) begin
      kbd_mask_next = wdata_in[3:0];
    end
  end

  // read mux, reserved bits come back as zero
  // status reads clear nothing, only writes do
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `RMSS_UNMAPPED_DATA;
    case (addr_in)
      `RMSS_OFF_MISC_STS: begin
        rd_mux = {{(8-NUM_EDGE){1'b0}}, misc_sts_reg} & `RMSS_MISC_STS_BITS;
      end
      `RMSS_OFF_FORCE_CHG: begin
        rd_mux = {6'h00, force_reg};
      end
      `RMSS_OFF_RATE_SHD: begin
        rd_mux = rate_shd_reg;
      end
      `RMSS_OFF_FIFO_SHD: begin
        rd_mux = fifo_shd_reg;
      end
      `RMSS_OFF_EDGE_SEL: begin
        rd_mux = {4'h0, edge_sel_reg};
      end
      // own offsets past the documented slice
      `RMSS_OFF_KBD_STS: begin
        rd_mux = {4'h0, kbd_sts_reg};
      end
      `RMSS_OFF_MISC_MASK: begin
        rd_mux = {{(8-NUM_EDGE){1'b0}}, misc_mask_reg};
      end
      `RMSS_OFF_KBD_MASK: begin
        rd_mux = {4'h0, kbd_mask_reg};
      end
      default: begin
        rd_mux = `RMSS_UNMAPPED_DATA; // unmapped address
      end
    endcase
  end

  // read data stand for exactly one cycle after the strobe
  // a read never changes any register, status included
  always @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else if (rd_in) begin
      // a read strobe latches the mux
      rdata_reg <= rd_mux;
    end else begin
      // idle cycles read back zero
      rdata_reg <= 8'h00;
    end
  end

  // disk change indication, registered so the output is a flop
  // costs one cycle of lag behind the select pins
  always @(posedge clk_in) begin
    if (srst_in) begin
      // indication off in reset
      chg_ind_reg <= 1'b0;
    end else begin
      // force terms use next values so a step clear shows at once
      chg_ind_reg <= (drv0_sel & force_next[`RMSS_FCHG_DRV0]) |
        (drv1_sel & force_next[`RMSS_FCHG_DRV1]) | ~disk_change_in_n_in;
    end
  end

  // interrupt level from next flag values, aligned with the flags
  // a write that clears the last flag drops irq in the same cycle
  always @(posedge clk_in) begin
    if (srst_in) begin
      // no interrupt in reset
      irq_reg <= 1'b0;
    end else begin
      // masks also taken at their next values
      irq_reg <= (|(misc_sts_next & misc_mask_next)) | (|(kbd_sts_next & kbd_mask_next));
    end
  end

  // outputs straight from flops
  // kbd flags leave for the smi and wake routing
  // the indication feeds the floppy input register bit 7
  assign rdata_out = rdata_reg;
  assign disk_change_indication_out = chg_ind_reg;
  assign kbd_event_out = kbd_sts_reg;
  assign irq_out = irq_reg;

endmodule // rmss_regs
`default_nettype wire

// ==== rmss_chk.sv ====
// port checker for the misc status and shadow register bank
`timescale 1ns/100ps
`default_nettype none
module rmss_chk (
  // clock, reset, register port
  input wire clk_in,
  input wire srst_in,
  input wire [7:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // floppy pins
  input wire drive0_select_n_in,
  input wire drive1_select_n_in,
  input wire disk_change_in_n_in,
  input wire disk_change_indication_out,
  // keyboard pin and flags
  input wire kbd_port_pin2_in,
  input wire [3:0] kbd_event_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // reserved read bits, seen in the data cycle
  misc_res_a: assert property (rd_in && addr_in == 8'h1C |=> rdata_out[7:6] == 2'b00)
    else $error("misc status top bits not zero");
  force_res_a: assert property (rd_in && addr_in == 8'h1E |=> rdata_out[7:2] == 6'h00)
    else $error("force register top bits not zero");
  rate_res_a: assert property (rd_in && addr_in == 8'h1F |=> !rdata_out[5])
    else $error("rate shadow bit five set");
  fifo_res_a: assert property (rd_in && addr_in == 8'h20 |=> rdata_out[5:4] == 2'b00)
    else $error("fifo shadow bits five four set");
  // disk change output lags its inputs by one cycle
  chg_ext_a: assert property (!disk_change_in_n_in |=> disk_change_indication_out)
    else $error("external change not shown");
  chg_none_a: assert property (drive0_select_n_in && drive1_select_n_in
    && disk_change_in_n_in |=> !disk_change_indication_out)
    else $error("change shown with no drive selected");
  // first cycle after reset has no previous pin sample
  kfall_a: assert property (!$past(srst_in) && $fell(kbd_port_pin2_in)
    |=> kbd_event_out[0] && kbd_event_out[2])
    else $error("falling pin edge missed");
  ksticky_a: assert property (kbd_event_out[0] && !(wr_in && addr_in == 8'h24)
    |=> kbd_event_out[0])
    else $error("keyboard flag dropped");
  // main scenarios reached
  c_chg: cover property (!disk_change_in_n_in);
  c_kfall: cover property ($fell(kbd_port_pin2_in));
  c_rd: cover property (rd_in && addr_in == 8'h1E);
endmodule // rmss_chk
bind rmss_regs rmss_chk chk_i (.clk_in, .srst_in, .addr_in, .wr_in, .rd_in, .rdata_out,
  .drive0_select_n_in, .drive1_select_n_in, .disk_change_in_n_in,
  .disk_change_indication_out, .kbd_port_pin2_in, .kbd_event_out);
`default_nettype wire

// ==== rmss_regs_tb.sv ====
// self-checking bench for the misc status and shadow register bank
`timescale 1ns/100ps
`default_nettype none
module rmss_regs_tb;
  reg clk_in = 1'b0;
  reg srst_in = 1'b1;
  reg [7:0] addr_in = 8'h00, wdata_in = 8'h00, rsd = 8'h00, fsd = 8'h00;
  reg wr_in = 1'b0, rd_in = 1'b0, rsw = 1'b0, fsw = 1'b0;
  reg [5:0] ep = 6'h00; // edge pins a..f
  reg step_n = 1'b1, ds0_n = 1'b1, ds1_n = 1'b1, chg_n = 1'b1, p2 = 1'b1, p6 = 1'b1;
  wire [7:0] rdata_out;
  wire chg_out, irq_out;
  wire [3:0] kev;
  integer n_fail = 0, cmp_count = 0;
  rmss_regs dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .edge_input_a_in(ep[0]), .edge_input_b_in(ep[1]), .edge_input_c_in(ep[2]),
    .edge_input_d_in(ep[3]), .edge_input_e_in(ep[4]), .edge_input_f_in(ep[5]),
    .step_pulse_n_in(step_n), .drive0_select_n_in(ds0_n), .drive1_select_n_in(ds1_n),
    .disk_change_in_n_in(chg_n), .disk_change_indication_out(chg_out),
    .rate_src_wr_in(rsw), .rate_src_data_in(rsd), .fifo_src_wr_in(fsw),
    .fifo_src_data_in(fsd), .kbd_port_pin2_in(p2), .kbd_port_pin6_in(p6),
    .kbd_event_out(kev), .irq_out(irq_out));
  // 200 MHz clock
  initial forever #2.5 clk_in = ~clk_in;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one-cycle bus strobes
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
    end
  endtask
  task t_reset;
    begin
      rd(8'h1C, 8'h00);
      rd(8'h1E, 8'h03);
      rd(8'h1F, 8'h02);
      rd(8'h20, 8'h00);
      wr(8'h30, 8'hFF);
      rd(8'h30, 8'h00);
      $display("reset test done");
    end
  endtask
  // each pin, rising then falling, with irq unmasked
  task t_edge;
    integer j;
    begin
      wr(8'h25, 8'h3F);
      for (j = 0; j < 12; j = j + 1) begin
        @(posedge clk_in) ep[j % 6] <= ~ep[j % 6];
        repeat (2) @(posedge clk_in);
        #1 chk({7'h00, irq_out}, 8'h01);
        rd(8'h1C, 8'h01 << (j % 6));
        wr(8'h1C, ~(8'h01 << (j % 6)));
        rd(8'h1C, 8'h01 << (j % 6));
        wr(8'h1C, 8'h01 << (j % 6));
        rd(8'h1C, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
      end
      // edge in the same cycle as its clear
      @(posedge clk_in) begin
        ep[0] <= ~ep[0];
        addr_in <= 8'h1C;
        wdata_in <= 8'h01;
        wr_in <= 1'b1;
      end
      @(posedge clk_in) wr_in <= 1'b0;
      rd(8'h1C, 8'h01);
      wr(8'h25, 8'h00);
      #1 chk({7'h00, irq_out}, 8'h00);
      rd(8'h25, 8'h00);
      wr(8'h1C, 8'h01);
      $display("edge test done");
    end
  endtask
  task t_force;
    begin
      @(posedge clk_in) ds0_n <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk({7'h00, chg_out}, 8'h01);
      @(posedge clk_in) step_n <= 1'b0;
      @(posedge clk_in) step_n <= 1'b1;
      rd(8'h1E, 8'h02);
      chk({7'h00, chg_out}, 8'h00);
      wr(8'h1E, 8'h00);
      rd(8'h1E, 8'h02);
      wr(8'h1E, 8'h01);
      rd(8'h1E, 8'h03);
      @(posedge clk_in) begin
        ds0_n <= 1'b1;
        ds1_n <= 1'b0;
      end
      repeat (2) @(posedge clk_in);
      #1 chk({7'h00, chg_out}, 8'h01);
      @(posedge clk_in) step_n <= 1'b0;
      @(posedge clk_in) step_n <= 1'b1;
      rd(8'h1E, 8'h01);
      chk({7'h00, chg_out}, 8'h00);
      // set write in the same cycle as a step clear, the set wins
      @(posedge clk_in) begin
        step_n <= 1'b0;
        addr_in <= 8'h1E;
        wdata_in <= 8'h02;
        wr_in <= 1'b1;
      end
      @(posedge clk_in) begin
        step_n <= 1'b1;
        wr_in <= 1'b0;
      end
      rd(8'h1E, 8'h03);
      // external change pin alone, no drive selected
      @(posedge clk_in) begin
        ds1_n <= 1'b1;
        chg_n <= 1'b0;
      end
      repeat (2) @(posedge clk_in);
      #1 chk({7'h00, chg_out}, 8'h01);
      @(posedge clk_in) chg_n <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 chk({7'h00, chg_out}, 8'h00);
      $display("force test done");
    end
  endtask
  // source register write, then shadows read back
  task src(input [7:0] r, input [7:0] f, input [7:0] er, input [7:0] ef);
    begin
      @(posedge clk_in) begin
        rsd <= r;
        fsd <= f;
        rsw <= 1'b1;
        fsw <= 1'b1;
      end
      @(posedge clk_in) begin
        rsw <= 1'b0;
        fsw <= 1'b0;
      end
      wr(8'h1F, 8'h00);
      wr(8'h20, 8'h00);
      rd(8'h1F, er);
      rd(8'h20, ef);
      $display("shadow test done");
    end
  endtask
  task kb(input s, input v, input [3:0] e);
    begin
      @(posedge clk_in) if (s) p6 <= v; else p2 <= v;
      repeat (2) @(posedge clk_in);
      #1 chk({4'h0, kev}, {4'h0, e});
    end
  endtask
  // one select bit at a time, then none
  task t_kbd;
    integer j;
    begin
      for (j = 0; j < 6; j = j + 1) begin
        wr(8'h21, j < 4 ? 8'h01 << j : 8'h00);
        kb(j[0], 1'b0, j[0] ? 4'hA : 4'h5);
        wr(8'h24, 8'h0F);
        kb(j[0], 1'b1, j < 4 ? 4'h1 << j : 4'h0);
        wr(8'h24, 8'h0F);
      end
      // keyboard flags reach irq through their own mask
      wr(8'h26, 8'h04);
      kb(1'b0, 1'b0, 4'h5);
      chk({7'h00, irq_out}, 8'h01);
      wr(8'h24, 8'h04);
      #1 chk({7'h00, irq_out}, 8'h00);
      rd(8'h24, 8'h01);
      rd(8'h26, 8'h04);
      rd(8'h21, 8'h00);
      wr(8'h24, 8'h0F);
      $display("keyboard test done");
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset;
    t_edge;
    t_force;
    src(8'hFF, 8'hFF, 8'hDF, 8'hCF);
    src(8'h25, 8'h31, 8'h05, 8'h01);
    t_kbd;
    end_of_test;
  end
  // hang guard
  initial begin
    #40000;
    n_fail = n_fail + 1;
    end_of_test;
  end
endmodule // rmss_regs_tb
`default_nettype wire
